// File: src/tcd_pkg.sv
// constants and types shared by the transmit command decoder
package tcd_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_DATA       = 8'h00;
   localparam logic [7:0]  REG_IRQ_STAT   = 8'h04;
   localparam logic [7:0]  REG_IRQ_MASK   = 8'h08;
   localparam logic [7:0]  REG_INFO       = 8'h0c;

   // ----------------------------------------------------------------
   // interrupt bits
   // ----------------------------------------------------------------
   localparam int          IRQ_W          = 2;
   localparam int          IRQ_LOADED     = 0;
   localparam int          IRQ_TXERR      = 1;
   localparam logic [1:0]  IRQ_RST        = 2'h0;

   // ----------------------------------------------------------------
   // command word a fields
   // ----------------------------------------------------------------
   localparam int          A_IOC          = 31;
   localparam int          A_ALIGN_HI     = 25;
   localparam int          A_ALIGN_LO     = 24;
   localparam int          A_OFF_HI       = 20;
   localparam int          A_OFF_LO       = 16;
   localparam int          A_FIRST        = 13;
   localparam int          A_LAST         = 12;
   localparam int          A_SIZE_HI      = 10;

   // ----------------------------------------------------------------
   // command word b fields
   // ----------------------------------------------------------------
   localparam int          B_TAG_HI       = 31;
   localparam int          B_TAG_LO       = 16;
   localparam int          B_LEN_HI       = 10;

   // ----------------------------------------------------------------
   // end alignment codes and dword masks
   // ----------------------------------------------------------------
   localparam logic [1:0]  ALIGN_4        = 2'h0;
   localparam logic [1:0]  ALIGN_16       = 2'h1;
   localparam logic [1:0]  ALIGN_32       = 2'h2;
   localparam logic [1:0]  ALIGN_RSVD     = 2'h3;
   localparam logic [10:0] PAD_MASK_4     = 11'h000;
   localparam logic [10:0] PAD_MASK_16    = 11'h003;
   localparam logic [10:0] PAD_MASK_32    = 11'h007;

   typedef enum logic [1:0] {
      ST_CMD_A,
      ST_CMD_B,
      ST_DATA
   } tcd_state_t;

endpackage

// File: src/tcd_lane_mask.sv
// byte enables and byte count of one payload dword
`timescale 1ns/10ps
`default_nettype none

module tcd_lane_mask
(
   input  wire logic [1:0]  lane_i,
   input  wire logic [11:0] left_i,
   output logic      [3:0]  be_o,
   output logic      [2:0]  cnt_o
);

   // ----------------------------------------------------------------
   // one enable per byte lane
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lane
         assign be_o[gi] = (gi >= lane_i) && ((gi - lane_i) < left_i);
      end
   endgenerate

   logic [2:0] room;

   always_comb
   begin
      room = 3'h4 - {1'b0, lane_i};
      if (left_i < {9'h000, room})
      begin
         cnt_o = left_i[2:0];
      end
      else
      begin
         cnt_o = room;
      end
   end

endmodule // tcd_lane_mask

`default_nettype wire

// File: src/tcd_top.sv
// transmit command decoder with wishbone slave and interrupt logic
// Contract
// - two command words, a then b, precede every buffer.
// - the tag in word b returns unchanged with the packet status.
// - differing word b within one packet raises the transmit error flag.
// - word a bit 31 sets buffer loaded flag when buffer fully taken.
// - word a bits 25:24 select 4, 16 or 32 byte end alignment.
// - padding dwords up to the alignment are dropped, never forwarded.
// - data start offset from 0 to 31 bytes locates first byte.
// - word a bits 13 and 12 mark first and last segment.
// - running sum of buffer sizes must equal packet length, else error.
// - word b holds tag 31:16 and packet length 10:0.
// - offset 1:0 picks first lane, offset 4:2 skips whole dwords.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module tcd_top
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   output logic      [31:0]       out_data_o,
   output logic      [3:0]        out_be_o,
   output logic                   out_sop_o,
   output logic                   out_eop_o,
   output logic                   out_valid_o,
   input  wire logic              out_ready_i,
   output logic                   status_valid_o,
   output logic      [15:0]       status_tag_o,
   output logic                   status_err_o,
   output logic                   irq_o
);

   generate
      if (ADDR_W < 4 || ADDR_W > 8)
      begin : g_chk
         $error("tcd_top: ADDR_W must lie in 4..8");
      end
   endgenerate

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   tcd_pkg::tcd_state_t state_r, state_nxt;
   logic [31:0]  a_r, a_nxt;
   logic [31:0]  pkt_b_r, pkt_b_nxt;
   logic [11:0]  sum_r, sum_nxt;
   logic [11:0]  left_r, left_nxt;
   logic [10:0]  idx_r, idx_nxt;
   logic [10:0]  total_r, total_nxt;
   logic         in_pkt_r, in_pkt_nxt;
   logic         pkt_err_r, pkt_err_nxt;
   logic         sop_pend_r, sop_pend_nxt;
   logic [31:0]  out_data_r, out_data_nxt;
   logic [3:0]   out_be_r, out_be_nxt;
   logic         out_sop_r, out_sop_nxt;
   logic         out_eop_r, out_eop_nxt;
   logic         out_valid_r, out_valid_nxt;
   logic         st_valid_r, st_valid_nxt;
   logic [15:0]  st_tag_r, st_tag_nxt;
   logic         st_err_r, st_err_nxt;
   logic [1:0]   stat_r, stat_nxt;
   logic [1:0]   mask_r, mask_nxt;
   logic         ack_r, ack_nxt;
   logic [31:0]  rdat_r, rdat_nxt;

   logic         ev_loaded;
   logic         ev_err;
   logic         buf_end;
   logic [10:0]  raw_dw;
   logic [10:0]  pad_mask;
   logic [12:0]  span;
   logic [2:0]   off_dw;
   logic [1:0]   lane;
   logic         is_payload;
   logic [3:0]   be_w;
   logic [2:0]   cnt_w;
   logic         req;
   logic         hit_data;
   logic         stall;
   logic         dp_wr;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   assign req        = wb_cyc_i && wb_stb_i && !ack_r;
   assign hit_data   = (wb_adr_i == tcd_pkg::REG_DATA[ADDR_W-1:0]);
   assign off_dw     = a_r[tcd_pkg::A_OFF_HI:tcd_pkg::A_OFF_LO+2];
   assign lane       = (idx_r == {8'h00, off_dw}) ? a_r[tcd_pkg::A_OFF_LO+1:tcd_pkg::A_OFF_LO]
                                                  : 2'h0;
   assign is_payload = (idx_r >= {8'h00, off_dw}) && (left_r != 12'h000);
   // payload waits while the output word is still held
   assign stall      = (state_r == tcd_pkg::ST_DATA) && is_payload && hit_data && wb_we_i &&
                       out_valid_r && !out_ready_i;
   assign dp_wr      = req && wb_we_i && hit_data && !stall;

   tcd_lane_mask u_mask
   (
      .lane_i (lane),
      .left_i (left_r),
      .be_o   (be_w),
      .cnt_o  (cnt_w)
   );

   // ----------------------------------------------------------------
   // buffer length in dwords, rounded to the end alignment
   // ----------------------------------------------------------------
   always_comb
   begin
      span = {8'h00, a_r[tcd_pkg::A_OFF_HI:tcd_pkg::A_OFF_LO]} +
             {2'h0, a_r[tcd_pkg::A_SIZE_HI:0]} + 13'h0003;
      raw_dw = span[12:2];
      case (a_r[tcd_pkg::A_ALIGN_HI:tcd_pkg::A_ALIGN_LO])
         tcd_pkg::ALIGN_16: pad_mask = tcd_pkg::PAD_MASK_16;
         tcd_pkg::ALIGN_32: pad_mask = tcd_pkg::PAD_MASK_32;
         default:           pad_mask = tcd_pkg::PAD_MASK_4;
      endcase
   end

   // ----------------------------------------------------------------
   // command decode and data path
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt     = state_r;
      a_nxt         = a_r;
      pkt_b_nxt     = pkt_b_r;
      sum_nxt       = sum_r;
      left_nxt      = left_r;
      idx_nxt       = idx_r;
      total_nxt     = total_r;
      in_pkt_nxt    = in_pkt_r;
      pkt_err_nxt   = pkt_err_r;
      sop_pend_nxt  = sop_pend_r;
      out_data_nxt  = out_data_r;
      out_be_nxt    = out_be_r;
      out_sop_nxt   = out_sop_r;
      out_eop_nxt   = out_eop_r;
      out_valid_nxt = out_valid_r && !out_ready_i;
      st_valid_nxt  = 1'b0;
      st_tag_nxt    = st_tag_r;
      st_err_nxt    = st_err_r;
      ev_loaded     = 1'b0;
      ev_err        = 1'b0;
      buf_end       = 1'b0;
      if (dp_wr)
      begin
         case (state_r)
            tcd_pkg::ST_CMD_A:
            begin
               a_nxt     = wb_dat_i;
               state_nxt = tcd_pkg::ST_CMD_B;
               if (wb_dat_i[tcd_pkg::A_ALIGN_HI:tcd_pkg::A_ALIGN_LO] == tcd_pkg::ALIGN_RSVD)
               begin
                  ev_err = 1'b1;
               end
            end
            tcd_pkg::ST_CMD_B:
            begin
               if (a_r[tcd_pkg::A_FIRST])
               begin
                  if (in_pkt_r)
                  begin
                     ev_err = 1'b1;
                  end
                  pkt_b_nxt    = wb_dat_i;
                  sum_nxt      = 12'h000;
                  pkt_err_nxt  = a_r[tcd_pkg::A_ALIGN_HI:tcd_pkg::A_ALIGN_LO] ==
                                 tcd_pkg::ALIGN_RSVD;
                  sop_pend_nxt = 1'b1;
               end
               else if (!in_pkt_r || (wb_dat_i != pkt_b_r))
               begin
                  ev_err = 1'b1;
               end
               in_pkt_nxt = 1'b1;
               idx_nxt    = 11'h000;
               left_nxt   = {1'b0, a_r[tcd_pkg::A_SIZE_HI:0]};
               total_nxt  = (raw_dw + pad_mask) & ~pad_mask;
               if (raw_dw == 11'h000)
               begin
                  buf_end = 1'b1;
               end
               else
               begin
                  state_nxt = tcd_pkg::ST_DATA;
               end
            end
            default:
            begin
               if (is_payload)
               begin
                  out_data_nxt  = wb_dat_i;
                  out_be_nxt    = be_w;
                  out_sop_nxt   = sop_pend_r;
                  out_eop_nxt   = a_r[tcd_pkg::A_LAST] && (left_r == {9'h000, cnt_w});
                  out_valid_nxt = 1'b1;
                  sop_pend_nxt  = 1'b0;
                  left_nxt      = left_r - {9'h000, cnt_w};
               end
               idx_nxt = idx_r + 11'h001;
               if (idx_nxt == total_r)
               begin
                  buf_end = 1'b1;
               end
            end
         endcase
      end
      if (buf_end)
      begin
         state_nxt = tcd_pkg::ST_CMD_A;
         ev_loaded = a_r[tcd_pkg::A_IOC];
         sum_nxt   = sum_nxt + {1'b0, a_r[tcd_pkg::A_SIZE_HI:0]};
         if (a_r[tcd_pkg::A_LAST])
         begin
            if (sum_nxt != {1'b0, pkt_b_nxt[tcd_pkg::B_LEN_HI:0]})
            begin
               ev_err = 1'b1;
            end
            in_pkt_nxt   = 1'b0;
            st_valid_nxt = 1'b1;
            st_tag_nxt   = pkt_b_nxt[tcd_pkg::B_TAG_HI:tcd_pkg::B_TAG_LO];
            st_err_nxt   = pkt_err_nxt || ev_err;
         end
      end
      pkt_err_nxt = pkt_err_nxt || ev_err;
   end

   // ----------------------------------------------------------------
   // registers, interrupts and read data
   // ----------------------------------------------------------------
   always_comb
   begin
      ack_nxt  = req && !stall;
      rdat_nxt = 32'h0000_0000;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      if (req && !stall && wb_we_i && wb_sel_i[0])
      begin
         if (wb_adr_i == tcd_pkg::REG_IRQ_STAT[ADDR_W-1:0])
         begin
            stat_nxt = stat_r & ~wb_dat_i[tcd_pkg::IRQ_W-1:0];
         end
         else if (wb_adr_i == tcd_pkg::REG_IRQ_MASK[ADDR_W-1:0])
         begin
            mask_nxt = wb_dat_i[tcd_pkg::IRQ_W-1:0];
         end
      end
      // set wins over a clear in the same cycle
      stat_nxt[tcd_pkg::IRQ_LOADED] = stat_nxt[tcd_pkg::IRQ_LOADED] || ev_loaded;
      stat_nxt[tcd_pkg::IRQ_TXERR]  = stat_nxt[tcd_pkg::IRQ_TXERR] || ev_err;
      if (req && !wb_we_i)
      begin
         if (wb_adr_i == tcd_pkg::REG_IRQ_STAT[ADDR_W-1:0])
         begin
            rdat_nxt[tcd_pkg::IRQ_W-1:0] = stat_r;
         end
         else if (wb_adr_i == tcd_pkg::REG_IRQ_MASK[ADDR_W-1:0])
         begin
            rdat_nxt[tcd_pkg::IRQ_W-1:0] = mask_r;
         end
         else if (wb_adr_i == tcd_pkg::REG_INFO[ADDR_W-1:0])
         begin
            rdat_nxt = {pkt_b_r[tcd_pkg::B_TAG_HI:tcd_pkg::B_TAG_LO], 13'h0000, in_pkt_r, state_r};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r     <= tcd_pkg::ST_CMD_A;
         a_r         <= 32'h0000_0000;
         pkt_b_r     <= 32'h0000_0000;
         sum_r       <= 12'h000;
         left_r      <= 12'h000;
         idx_r       <= 11'h000;
         total_r     <= 11'h000;
         in_pkt_r    <= 1'b0;
         pkt_err_r   <= 1'b0;
         sop_pend_r  <= 1'b0;
         out_data_r  <= 32'h0000_0000;
         out_be_r    <= 4'h0;
         out_sop_r   <= 1'b0;
         out_eop_r   <= 1'b0;
         out_valid_r <= 1'b0;
         st_valid_r  <= 1'b0;
         st_tag_r    <= 16'h0000;
         st_err_r    <= 1'b0;
         stat_r      <= tcd_pkg::IRQ_RST;
         mask_r      <= tcd_pkg::IRQ_RST;
         ack_r       <= 1'b0;
         rdat_r      <= 32'h0000_0000;
      end
      else
      begin
         state_r     <= state_nxt;
         a_r         <= a_nxt;
         pkt_b_r     <= pkt_b_nxt;
         sum_r       <= sum_nxt;
         left_r      <= left_nxt;
         idx_r       <= idx_nxt;
         total_r     <= total_nxt;
         in_pkt_r    <= in_pkt_nxt;
         pkt_err_r   <= pkt_err_nxt;
         sop_pend_r  <= sop_pend_nxt;
         out_data_r  <= out_data_nxt;
         out_be_r    <= out_be_nxt;
         out_sop_r   <= out_sop_nxt;
         out_eop_r   <= out_eop_nxt;
         out_valid_r <= out_valid_nxt;
         st_valid_r  <= st_valid_nxt;
         st_tag_r    <= st_tag_nxt;
         st_err_r    <= st_err_nxt;
         stat_r      <= stat_nxt;
         mask_r      <= mask_nxt;
         ack_r       <= ack_nxt;
         rdat_r      <= rdat_nxt;
      end
   end

   assign wb_ack_o       = ack_r;
   assign wb_dat_o       = rdat_r;
   assign out_data_o     = out_data_r;
   assign out_be_o       = out_be_r;
   assign out_sop_o      = out_sop_r;
   assign out_eop_o      = out_eop_r;
   assign out_valid_o    = out_valid_r;
   assign status_valid_o = st_valid_r;
   assign status_tag_o   = st_tag_r;
   assign status_err_o   = st_err_r;
   assign irq_o          = |(stat_r & mask_r);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   cmd_order_a: assert property (dp_wr && state_r == tcd_pkg::ST_CMD_A |=>
      state_r == tcd_pkg::ST_CMD_B) else $error("word a not followed by word b state");
   tag_return_a: assert property (st_valid_r |->
      st_tag_r == pkt_b_r[tcd_pkg::B_TAG_HI:tcd_pkg::B_TAG_LO]) else $error("tag changed");
   b_mismatch_a: assert property (dp_wr && state_r == tcd_pkg::ST_CMD_B &&
      !a_r[tcd_pkg::A_FIRST] && wb_dat_i != pkt_b_r |=> stat_r[tcd_pkg::IRQ_TXERR])
      else $error("word b mismatch not flagged");
   loaded_flag_a: assert property (buf_end && a_r[tcd_pkg::A_IOC] |=>
      stat_r[tcd_pkg::IRQ_LOADED] && state_r == tcd_pkg::ST_CMD_A)
      else $error("loaded flag missing");
   align_32_a: assert property (state_r == tcd_pkg::ST_DATA &&
      a_r[tcd_pkg::A_ALIGN_HI:tcd_pkg::A_ALIGN_LO] == tcd_pkg::ALIGN_32 |->
      total_r[2:0] == 3'h0) else $error("buffer not padded to 32 bytes");
   pad_drop_a: assert property (dp_wr && state_r == tcd_pkg::ST_DATA && !is_payload &&
      !out_valid_r |=> !out_valid_r) else $error("padding forwarded");
   first_lane_a: assert property (dp_wr && state_r == tcd_pkg::ST_DATA && is_payload |=>
      out_valid_r && ((out_be_r & ((4'h1 << $past(lane)) - 4'h1)) == 4'h0))
      else $error("byte below start lane enabled");
   last_seg_a: assert property (st_valid_r |-> $past(a_r[tcd_pkg::A_LAST]) && !in_pkt_r)
      else $error("status without last segment");
   len_check_a: assert property (buf_end && a_r[tcd_pkg::A_LAST] &&
      sum_nxt != {1'b0, pkt_b_nxt[tcd_pkg::B_LEN_HI:0]} |=>
      st_err_r && stat_r[tcd_pkg::IRQ_TXERR]) else $error("length mismatch not flagged");
   eop_mark_a: assert property (dp_wr && state_r == tcd_pkg::ST_DATA && is_payload &&
      a_r[tcd_pkg::A_LAST] && left_r == {9'h000, cnt_w} |=> out_eop_r && left_r == 12'h000)
      else $error("end of packet not marked");
   dword_skip_a: assert property (dp_wr && state_r == tcd_pkg::ST_DATA &&
      idx_r < {8'h00, off_dw} |=> left_r == $past(left_r)) else $error("skipped dword used");

endmodule // tcd_top

`default_nettype wire

// File: verif/tcd_sink.sv
// stream sink that stands behind the decoder output and tallies words
`timescale 1ns/10ps
`default_nettype none

module tcd_sink
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        stall_i,
   input  wire logic        clr_i,
   input  wire logic        valid_i,
   input  wire logic [31:0] data_i,
   input  wire logic [3:0]  be_i,
   input  wire logic        sop_i,
   input  wire logic        eop_i,
   output logic             ready_o,
   output logic      [7:0]  words_o,
   output logic      [7:0]  sops_o,
   output logic      [7:0]  eops_o,
   output logic      [3:0]  first_be_o,
   output logic      [3:0]  last_be_o,
   output logic      [31:0] first_data_o
);
   logic toggle_r;

   // slow mode accepts every other cycle
   assign ready_o = ~stall_i | toggle_r;

   always_ff @(posedge clk_i)
   begin
      toggle_r <= rst_i ? 1'b0 : ~toggle_r;
      if (rst_i || clr_i)
      begin
         words_o <= 8'h00;
         sops_o  <= 8'h00;
         eops_o  <= 8'h00;
      end
      else if (valid_i && ready_o)
      begin
         if (words_o == 8'h00)
         begin
            first_be_o   <= be_i;
            first_data_o <= data_i;
         end
         last_be_o <= be_i;
         words_o   <= words_o + 8'h01;
         sops_o    <= sops_o + {7'h00, sop_i};
         eops_o    <= eops_o + {7'h00, eop_i};
      end
   end
endmodule // tcd_sink

`default_nettype wire

// File: verif/tcd_top_tb_top.sv
// self-checking bench for the transmit command decoder
`timescale 1ns/10ps
`default_nettype none

module tcd_top_tb_top;
   // ----------------------------------------------------------------
   // signals and case table
   // ----------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0;
   logic        stall = 1'b0;
   logic        clr   = 1'b0;
   logic [31:0] wb_dat_o, out_data_o, s_fdata;
   logic [15:0] status_tag_o;
   logic [7:0]  s_words, s_sops, s_eops;
   logic [7:0]  st_cnt = 8'h00;
   logic [3:0]  out_be_o, s_fbe, s_lbe;
   logic        wb_ack_o, out_sop_o, out_eop_o, out_valid_o, ready;
   logic        status_valid_o, status_err_o, irq_o;
   int          fail_count = 0;
   int          check_count = 0;

   localparam logic [31:0] CA1 [7] = '{32'h8000_3008, 32'h0105_3006, 32'h0200_3003,
      32'h8000_2004, 32'h0000_2004, 32'h0000_3004, 32'h0300_3004};
   localparam logic [31:0] CB1 [7] = '{32'habcd_0008, 32'h1234_0006, 32'h5678_0003,
      32'h1111_0008, 32'h1111_0008, 32'h2222_0008, 32'h3333_0004};
   localparam logic [31:0] CA2 [7] = '{32'h0, 32'h0, 32'h0, 32'h0000_1004,
      32'h0000_1004, 32'h0, 32'h0};
   localparam logic [31:0] CB2 [7] = '{32'h0, 32'h0, 32'h0, 32'h1111_0008,
      32'h2222_0008, 32'h0, 32'h0};
   localparam logic [6:0]  ERR     = 7'h70;
   localparam logic [7:0]  WORDS [7] = '{8'h02, 8'h02, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01};
   localparam logic [3:0]  FBE [7] = '{4'hf, 4'he, 4'h7, 4'hf, 4'hf, 4'hf, 4'hf};
   localparam logic [3:0]  LBE [7] = '{4'hf, 4'h7, 4'h7, 4'hf, 4'hf, 4'hf, 4'hf};

   always #2.5 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      if (status_valid_o === 1'b1)
         st_cnt <= st_cnt + 8'h01;
   end

   tcd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .out_data_o(out_data_o), .out_be_o(out_be_o),
      .out_sop_o(out_sop_o), .out_eop_o(out_eop_o), .out_valid_o(out_valid_o),
      .out_ready_i(ready), .status_valid_o(status_valid_o), .status_tag_o(status_tag_o),
      .status_err_o(status_err_o), .irq_o(irq_o));

   tcd_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .clr_i(clr),
      .valid_i(out_valid_o), .data_i(out_data_o), .be_i(out_be_o), .sop_i(out_sop_o),
      .eop_i(out_eop_o), .ready_o(ready), .words_o(s_words), .sops_o(s_sops),
      .eops_o(s_eops), .first_be_o(s_fbe), .last_be_o(s_lbe), .first_data_o(s_fdata));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", name, e, g);
         fail_count++;
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 500);
      q = wb_dat_o;
      cyc <= 1'b0;
      we  <= 1'b0;
      if (wb_ack_o !== 1'b1)
      begin
         fail_count++;
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   function automatic int n_dw(input logic [31:0] a);
      int d;
      int m;
      d = (int'(a[20:16]) + int'(a[10:0]) + 3) / 4;
      m = (a[25:24] == tcd_pkg::ALIGN_16) ? 4 : ((a[25:24] == tcd_pkg::ALIGN_32) ? 8 : 1);
      return ((d + m - 1) / m) * m;
   endfunction

   task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] base);
      int n;
      n = n_dw(a);
      // both command words, reserved bits zero
      wr(tcd_pkg::REG_DATA, a);
      wr(tcd_pkg::REG_DATA, b);
      // host pads up to the end alignment
      for (int i = 0; i < n; i++)
         wr(tcd_pkg::REG_DATA, base + 32'(i));
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (out_valid_o !== 1'b0 && n < 100)
      begin
         @(posedge clk_i);
         n++;
      end
      if (out_valid_o !== 1'b0)
      begin
         fail_count++;
         final_report();
      end
      repeat (3) @(posedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] q;
      logic [7:0]  st0;
      logic        ioc;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, tcd_pkg::REG_IRQ_STAT, 32'h0, q);
      chk("stat reset", 32'h0, q);
      wb(1'b0, tcd_pkg::REG_IRQ_MASK, 32'h0, q);
      chk("mask reset", 32'h0, q);
      wr(8'h10, 32'hffff_ffff);
      wb(1'b0, 8'h10, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      $display("test reset done");
      for (int k = 0; k < 7; k++)
      begin
         stall <= (k == 1 || k == 3);
         clr   <= 1'b1;
         @(posedge clk_i);
         clr <= 1'b0;
         st0 = st_cnt;
         ioc = CA1[k][31] | CA2[k][31];
         send_buf(CA1[k], CB1[k], 32'(k) << 8);
         if (CA2[k] != 32'h0)
            send_buf(CA2[k], CB2[k], (32'(k) << 8) + 32'h80);
         drain();
         chk("words", {24'h0, WORDS[k]}, {24'h0, s_words});
         chk("first be", {28'h0, FBE[k]}, {28'h0, s_fbe});
         chk("last be", {28'h0, LBE[k]}, {28'h0, s_lbe});
         chk("first data", (32'(k) << 8) + 32'(CA1[k][20:18]), s_fdata);
         chk("sop count", 32'h1, {24'h0, s_sops});
         chk("eop count", 32'h1, {24'h0, s_eops});
         chk("status count", 32'h1, {24'h0, st_cnt - st0});
         chk("status err", {31'h0, ERR[k]}, {31'h0, status_err_o});
         if (!ERR[k])
            chk("status tag", {16'h0, CB1[k][31:16]}, {16'h0, status_tag_o});
         wb(1'b0, tcd_pkg::REG_IRQ_STAT, 32'h0, q);
         chk("stat", {30'h0, ERR[k], ioc}, q);
         wb(1'b0, tcd_pkg::REG_INFO, 32'h0, q);
         chk("info", {CB1[k][31:16], 16'h0}, q);
         chk("irq", {31'h0, (k > 0) && (ERR[k] || ioc)}, {31'h0, irq_o});
         wr(tcd_pkg::REG_IRQ_STAT, 32'h3);
         chk("irq cleared", 32'h0, {31'h0, irq_o});
         if (k == 0)
         begin
            wr(tcd_pkg::REG_IRQ_MASK, 32'h3);
            wb(1'b0, tcd_pkg::REG_IRQ_MASK, 32'h0, q);
            chk("mask", 32'h3, q);
         end
         $display("test case %0d done", k);
      end
      final_report();
   end
endmodule // tcd_top_tb_top

`default_nettype wire
